/* shared/lpddr_pin_pkg.sv */
// Constants, command codes and state encodings for the memory pin interface.
// Assumes an x16 build: two byte lanes, four banks, 13 row and 10 column bits.
package lpddr_pin_pkg;

  // ------
  // Array geometry
  // ------
  localparam int BANK_BITS = 2;
  localparam int BANKS = 4;
  localparam int ROW_BITS = 13;
  localparam int COL_BITS = 10;
  localparam int DATA_BITS = 16;
  localparam int LANES = 2;
  localparam int BYTE_BITS = 8;

  // ------
  // Address line fields
  // ------
  localparam int AUTO_PRECHARGE_POS = 10;
  localparam int BURST_LEN_LSB = 0;
  localparam int BURST_LEN_MSB = 2;
  localparam int BURST_TYPE_POS = 3;
  localparam int CAS_LAT_LSB = 4;
  localparam int CAS_LAT_MSB = 6;
  localparam int MODE_BITS = 7;

  // Mode register has no defined power-up value; zero is used here
  localparam logic [MODE_BITS-1:0] MODE_RESET = 7'h00;
  localparam logic [ROW_BITS-1:0] EXT_MODE_RESET = 13'h0000;
  localparam logic [BANK_BITS-1:0] BASE_MODE_BANK = 2'h0;

  // Burst length codes and their count of clock cycles (beat pairs)
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_16 = 3'h4;
  localparam logic [3:0] PAIRS_2 = 4'h1;
  localparam logic [3:0] PAIRS_4 = 4'h2;
  localparam logic [3:0] PAIRS_8 = 4'h4;
  localparam logic [3:0] PAIRS_16 = 4'h8;
  localparam logic [2:0] CL_CODE_3 = 3'h3;

  // ------
  // Command word {chip_select_n, row, column, write strobes}
  // ------
  localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_BURST_STOP = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // ------
  // Power states and buffering
  // ------
  typedef enum logic [3:0] {
    PWR_RUN = 4'h1,
    PWR_PRECHARGE_DOWN = 4'h2,
    PWR_ACTIVE_DOWN = 4'h4,
    PWR_SELF_REFRESH = 4'h8
  } power_type;

  localparam int FIFO_DEPTH = 8;
  localparam int WRITE_WORD_BITS = BANK_BITS + ROW_BITS + 2 * COL_BITS + 2 * DATA_BITS + 2 * LANES;

endpackage : lpddr_pin_pkg

/* rtl/lpddr_pin_interface.sv */
// Device-side pin logic of a low-power DDR memory plus the write beat FIFO.
// Assumes DDR pad cells outside split each data pin into rise and fall words
// captured by the data strobe, and that array reads run on the link clock and array writes on clk.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Dual-clock FIFO with gray pointers and a registered read stage
// ------------------------------------------------------------------
module write_beat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic wr_clk,
  input wire logic wr_reset,
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  input wire logic rd_clk,
  input wire logic rd_reset,
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data,
  input wire logic rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_bin;
  logic [AW:0] wr_gray;
  logic [AW:0] rd_bin;
  logic [AW:0] rd_gray;
  logic [AW:0] rd_gray_meta;
  logic [AW:0] rd_gray_sync;
  logic [AW:0] wr_gray_meta;
  logic [AW:0] wr_gray_sync;
  logic [AW:0] next_wr_bin;
  logic [AW:0] next_wr_gray;
  logic [AW:0] next_rd_bin;
  logic push;
  logic load;

  assign push = wr_valid && wr_ready;
  assign next_wr_bin = wr_bin + (AW+1)'(push);
  assign next_wr_gray = (next_wr_bin >> 1) ^ next_wr_bin;
  assign load = (!rd_valid || rd_ready) && (rd_gray != wr_gray_sync);
  assign next_rd_bin = rd_bin + (AW+1)'(1);

  always_ff @(posedge wr_clk)
  begin
    if (push)
    begin
      mem[wr_bin[AW-1:0]] <= wr_data;
    end
  end

  // Ready is computed against a lagging read pointer, so it only errs toward full
  always_ff @(posedge wr_clk)
  begin
    if (wr_reset)
    begin
      wr_bin <= '0;
      wr_gray <= '0;
      wr_ready <= 1'b0;
    end
    else
    begin
      wr_bin <= next_wr_bin;
      wr_gray <= next_wr_gray;
      wr_ready <= next_wr_gray != {~rd_gray_sync[AW:AW-1], rd_gray_sync[AW-2:0]};
    end
  end

  always_ff @(posedge wr_clk)
  begin
    rd_gray_meta <= rd_gray;
    rd_gray_sync <= rd_gray_meta;
  end

  always_ff @(posedge rd_clk)
  begin
    wr_gray_meta <= wr_gray;
    wr_gray_sync <= wr_gray_meta;
  end

  always_ff @(posedge rd_clk)
  begin
    if (rd_reset)
    begin
      rd_bin <= '0;
      rd_gray <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end
    else if (load)
    begin
      rd_data <= mem[rd_bin[AW-1:0]];
      rd_bin <= next_rd_bin;
      rd_gray <= (next_rd_bin >> 1) ^ next_rd_bin;
      rd_valid <= 1'b1;
    end
    else if (rd_ready)
    begin
      rd_valid <= 1'b0;
    end
  end
endmodule : write_beat_fifo

module lpddr_pin_interface (
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic gating_input,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [lpddr_pin_pkg::BANK_BITS-1:0] bank_select_bits,
  input wire logic [lpddr_pin_pkg::ROW_BITS-1:0] address_lines,
  input wire logic [lpddr_pin_pkg::DATA_BITS-1:0] dq_in_rise,
  input wire logic [lpddr_pin_pkg::DATA_BITS-1:0] dq_in_fall,
  input wire logic [lpddr_pin_pkg::LANES-1:0] write_byte_mask_rise,
  input wire logic [lpddr_pin_pkg::LANES-1:0] write_byte_mask_fall,
  output logic [lpddr_pin_pkg::DATA_BITS-1:0] dq_out_rise,
  output logic [lpddr_pin_pkg::DATA_BITS-1:0] dq_out_fall,
  output logic dq_oe,
  output logic [lpddr_pin_pkg::LANES-1:0] data_strobe_out_rise,
  output logic [lpddr_pin_pkg::LANES-1:0] data_strobe_out_fall,
  output logic [lpddr_pin_pkg::LANES-1:0] data_strobe_oe,
  output logic input_buffers_on,
  output logic array_read_valid,
  output logic [lpddr_pin_pkg::BANK_BITS-1:0] array_read_bank,
  output logic [lpddr_pin_pkg::ROW_BITS-1:0] array_read_row,
  output logic [lpddr_pin_pkg::COL_BITS-1:0] array_read_col_rise,
  output logic [lpddr_pin_pkg::COL_BITS-1:0] array_read_col_fall,
  input wire logic [lpddr_pin_pkg::DATA_BITS-1:0] array_read_data_rise,
  input wire logic [lpddr_pin_pkg::DATA_BITS-1:0] array_read_data_fall,
  output logic write_valid,
  input wire logic write_ready,
  output logic [lpddr_pin_pkg::WRITE_WORD_BITS-1:0] write_word,
  output logic overrun_flag,
  input wire logic overrun_clear,
  output logic [3:0] power_state_core
);
  import lpddr_pin_pkg::*;

  // ----------------------------------------------------------------
  // Reset into the link domain and command decode
  // ----------------------------------------------------------------
  logic link_reset_meta;
  logic link_reset;
  logic gating_prev;
  logic [3:0] command_word;
  logic cmd_live;
  logic [MODE_BITS-1:0] mode_reg;
  logic [ROW_BITS-1:0] ext_mode_reg;
  logic [BANKS-1:0] row_open;
  logic [ROW_BITS-1:0] open_row [BANKS];
  power_type power_state;
  logic self_refresh_flag;
  logic sr_meta;
  logic sr_sync;
  logic sr_prev;
  logic sr_entry;

  always_ff @(posedge link_clk)
  begin
    link_reset_meta <= reset;
    link_reset <= link_reset_meta;
    gating_prev <= gating_input;
  end

  assign command_word = {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n};
  // Decoding needs clock enable high on this and the previous edge
  assign cmd_live = (power_state == PWR_RUN) && gating_prev && gating_input && !chip_select_n;
  assign sr_entry = (power_state == PWR_RUN) && gating_prev && !gating_input && !chip_select_n
                    && (command_word == CMD_REFRESH);

  function automatic logic [3:0] burst_pairs(input logic [2:0] code);
    case (code)
      BL_CODE_2: burst_pairs = PAIRS_2;
      BL_CODE_4: burst_pairs = PAIRS_4;
      BL_CODE_8: burst_pairs = PAIRS_8;
      BL_CODE_16: burst_pairs = PAIRS_16;
      default: burst_pairs = PAIRS_2;
    endcase
  endfunction : burst_pairs

  // Wraps inside the block that the burst length selects
  function automatic logic [COL_BITS-1:0] burst_col(input logic [COL_BITS-1:0] start, input logic [4:0] offset,
                                                     input logic [3:0] pairs, input logic interleave);
    logic [COL_BITS-1:0] span;
    logic [COL_BITS-1:0] off;
    span = COL_BITS'({pairs, 1'b0}) - COL_BITS'(1);
    off = COL_BITS'(offset);
    if (interleave)
      burst_col = start ^ off;
    else
      burst_col = (start & ~span) | ((start + off) & span);
  endfunction : burst_col

  logic [3:0] pairs;
  logic interleave;
  logic cas_three;

  assign pairs = burst_pairs(mode_reg[BURST_LEN_MSB:BURST_LEN_LSB]);
  assign interleave = mode_reg[BURST_TYPE_POS];
  assign cas_three = mode_reg[CAS_LAT_MSB:CAS_LAT_LSB] == CL_CODE_3;

  always_ff @(posedge link_clk)
  begin
    if (link_reset)
    begin
      mode_reg <= MODE_RESET;
      ext_mode_reg <= EXT_MODE_RESET;
    end
    else if (cmd_live && command_word == CMD_MODE_LOAD)
    begin
      if (bank_select_bits == BASE_MODE_BANK)
        mode_reg <= address_lines[MODE_BITS-1:0];
      else
        ext_mode_reg <= address_lines;
    end
  end

  // ----------------------------------------------------------------
  // Burst sequencing
  // ----------------------------------------------------------------
  logic [3:0] wr_left;
  logic [4:0] wr_index;
  logic [BANK_BITS-1:0] wr_bank;
  logic [COL_BITS-1:0] wr_col;
  logic wr_auto_pre;
  logic [3:0] rd_left;
  logic [4:0] rd_index;
  logic [BANK_BITS-1:0] rd_bank;
  logic [COL_BITS-1:0] rd_col;
  logic rd_auto_pre;
  logic is_read;
  logic is_write;
  logic wr_close;
  logic rd_close;
  logic fifo_wr_valid;
  logic fifo_wr_ready;
  logic [WRITE_WORD_BITS-1:0] fifo_wr_data;

  assign is_read = cmd_live && command_word == CMD_READ;
  assign is_write = cmd_live && command_word == CMD_WRITE;
  assign wr_close = wr_auto_pre && wr_left == 4'h1;
  // A two-beat read closes on its own command edge, so it must use the bit on the pins
  assign rd_close = is_read ? (pairs == PAIRS_2 && address_lines[AUTO_PRECHARGE_POS]) : (rd_auto_pre && rd_left == 4'h1);

  // A new burst or a burst stop ends whatever burst is running
  always_ff @(posedge link_clk)
  begin
    if (link_reset || (cmd_live && command_word == CMD_BURST_STOP) || is_read)
    begin
      wr_left <= 4'h0;
      wr_index <= 5'h00;
      wr_auto_pre <= 1'b0;
    end
    else if (is_write)
    begin
      wr_left <= pairs;
      wr_index <= 5'h00;
      wr_bank <= bank_select_bits;
      wr_col <= address_lines[COL_BITS-1:0];
      wr_auto_pre <= address_lines[AUTO_PRECHARGE_POS];
    end
    else if (wr_left != 4'h0)
    begin
      wr_left <= wr_left - 4'h1;
      wr_index <= wr_index + 5'h02;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (link_reset || (cmd_live && command_word == CMD_BURST_STOP) || is_write)
    begin
      rd_left <= 4'h0;
      rd_index <= 5'h00;
      rd_auto_pre <= 1'b0;
      array_read_valid <= 1'b0;
    end
    else if (is_read)
    begin
      rd_left <= pairs - 4'h1;
      rd_index <= 5'h02;
      rd_bank <= bank_select_bits;
      rd_col <= address_lines[COL_BITS-1:0];
      rd_auto_pre <= address_lines[AUTO_PRECHARGE_POS];
      array_read_valid <= 1'b1;
      array_read_bank <= bank_select_bits;
      array_read_row <= open_row[bank_select_bits];
      array_read_col_rise <= burst_col(address_lines[COL_BITS-1:0], 5'h00, pairs, interleave);
      array_read_col_fall <= burst_col(address_lines[COL_BITS-1:0], 5'h01, pairs, interleave);
    end
    else if (rd_left != 4'h0)
    begin
      rd_left <= rd_left - 4'h1;
      rd_index <= rd_index + 5'h02;
      array_read_valid <= 1'b1;
      array_read_col_rise <= burst_col(rd_col, rd_index, pairs, interleave);
      array_read_col_fall <= burst_col(rd_col, rd_index + 5'h01, pairs, interleave);
    end
    else
    begin
      array_read_valid <= 1'b0;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (link_reset)
    begin
      row_open <= '0;
    end
    else
    begin
      if (cmd_live && command_word == CMD_ACTIVE)
      begin
        row_open[bank_select_bits] <= 1'b1;
        open_row[bank_select_bits] <= address_lines;
      end
      if (cmd_live && command_word == CMD_PRECHARGE)
      begin
        if (address_lines[AUTO_PRECHARGE_POS])
          row_open <= '0;
        else
          row_open[bank_select_bits] <= 1'b0;
      end
      if (wr_close)
        row_open[wr_bank] <= 1'b0;
      if (rd_close)
        row_open[is_read ? bank_select_bits : rd_bank] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write beats into the FIFO, read beats onto the pins
  // ----------------------------------------------------------------
  // Write latency is one cycle: the first pair is taken the edge after the command
  assign fifo_wr_valid = wr_left != 4'h0;
  assign fifo_wr_data = {wr_bank, open_row[wr_bank],
                         burst_col(wr_col, wr_index, pairs, interleave),
                         burst_col(wr_col, wr_index + 5'h01, pairs, interleave),
                         dq_in_rise, dq_in_fall,
                         ~write_byte_mask_rise, ~write_byte_mask_fall};

  logic overrun_toggle;

  // The controller cannot be stalled, so a refused beat is reported instead
  always_ff @(posedge link_clk)
  begin
    if (link_reset)
      overrun_toggle <= 1'b0;
    else if (fifo_wr_valid && !fifo_wr_ready)
      overrun_toggle <= ~overrun_toggle;
  end

  logic [1:0] req_pipe;
  logic drive;

  assign drive = cas_three ? req_pipe[0] : array_read_valid;

  always_ff @(posedge link_clk)
  begin
    if (link_reset)
    begin
      req_pipe <= 2'h0;
      dq_oe <= 1'b0;
      data_strobe_oe <= '0;
      dq_out_rise <= '0;
      dq_out_fall <= '0;
      data_strobe_out_rise <= '0;
      data_strobe_out_fall <= '0;
    end
    else
    begin
      req_pipe <= {req_pipe[0], array_read_valid};
      dq_oe <= drive && gating_input;
      data_strobe_oe <= {LANES{drive && gating_input}};
      dq_out_rise <= drive ? array_read_data_rise : '0;
      dq_out_fall <= drive ? array_read_data_fall : '0;
      data_strobe_out_rise <= {LANES{drive}};
      data_strobe_out_fall <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Power control
  // ----------------------------------------------------------------
  // Exit from self refresh must work with the link clock stopped
  always_ff @(posedge link_clk or posedge gating_input)
  begin
    if (gating_input)
      self_refresh_flag <= 1'b0;
    else if (link_reset)
      self_refresh_flag <= 1'b0;
    else if (sr_entry)
      self_refresh_flag <= 1'b1;
  end

  always_ff @(posedge link_clk)
  begin
    sr_meta <= self_refresh_flag;
    sr_sync <= sr_meta;
    sr_prev <= sr_sync;
  end

  always_ff @(posedge link_clk)
  begin
    if (link_reset)
    begin
      power_state <= PWR_RUN;
      input_buffers_on <= 1'b1;
    end
    else
    begin
      case (power_state)
        PWR_RUN:
          if (gating_prev && !gating_input)
          begin
            input_buffers_on <= 1'b0;
            if (sr_entry)
              power_state <= PWR_SELF_REFRESH;
            else if (row_open != '0)
              power_state <= PWR_ACTIVE_DOWN;
            else
              power_state <= PWR_PRECHARGE_DOWN;
          end
        PWR_PRECHARGE_DOWN, PWR_ACTIVE_DOWN:
          if (gating_input)
          begin
            power_state <= PWR_RUN;
            input_buffers_on <= 1'b1;
          end
        PWR_SELF_REFRESH:
          if (sr_prev && !sr_sync)
          begin
            power_state <= PWR_RUN;
            input_buffers_on <= 1'b1;
          end
        default:
        begin
          power_state <= PWR_RUN;
          input_buffers_on <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core clock side
  // ----------------------------------------------------------------
  write_beat_fifo #(
    .WIDTH(WRITE_WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) beat_fifo (
    .wr_clk(link_clk),
    .wr_reset(link_reset),
    .wr_valid(fifo_wr_valid),
    .wr_data(fifo_wr_data),
    .wr_ready(fifo_wr_ready),
    .rd_clk(clk),
    .rd_reset(reset),
    .rd_valid(write_valid),
    .rd_data(write_word),
    .rd_ready(write_ready)
  );

  logic overrun_meta;
  logic overrun_sync;
  logic overrun_seen;
  logic [3:0] power_meta;
  logic [3:0] power_sync;

  // Taken only when two samples agree, so a one-hot change in flight never shows mixed
  always_ff @(posedge clk)
  begin
    overrun_meta <= overrun_toggle;
    overrun_sync <= overrun_meta;
    overrun_seen <= overrun_sync;
    power_meta <= power_state;
    power_sync <= power_meta;
    if (power_sync == power_meta)
      power_state_core <= power_sync;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      overrun_flag <= 1'b0;
    else if (overrun_sync != overrun_seen)
      overrun_flag <= 1'b1;
    else if (overrun_clear)
      overrun_flag <= 1'b0;
  end
endmodule : lpddr_pin_interface

/* test/lpddr_pin_interface_sva.sv */
// Checker for the pin interface: command decode, read strobes, power and FIFO.
// Assumes binding into lpddr_pin_interface; clk and link_clk are unrelated.
`timescale 1ns/1ps
module lpddr_pin_interface_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic gating_input,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [lpddr_pin_pkg::BANK_BITS-1:0] bank_select_bits,
  input wire logic dq_oe,
  input wire logic [lpddr_pin_pkg::LANES-1:0] data_strobe_out_rise,
  input wire logic [lpddr_pin_pkg::LANES-1:0] data_strobe_out_fall,
  input wire logic [lpddr_pin_pkg::LANES-1:0] data_strobe_oe,
  input wire logic input_buffers_on,
  input wire logic array_read_valid,
  input wire logic [lpddr_pin_pkg::BANK_BITS-1:0] array_read_bank,
  input wire logic [lpddr_pin_pkg::COL_BITS-1:0] array_read_col_rise,
  input wire logic [lpddr_pin_pkg::COL_BITS-1:0] array_read_col_fall,
  input wire logic write_valid,
  input wire logic write_ready,
  input wire logic [lpddr_pin_pkg::WRITE_WORD_BITS-1:0] write_word
);
  import lpddr_pin_pkg::*;
  logic [3:0] cmd_word;
  assign cmd_word = {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n};
  // ------
  // Link domain
  // ------
  cs_high_mask_a: assert property (@(posedge link_clk) disable iff (reset)
    chip_select_n && !array_read_valid |=> !array_read_valid) else $error("Read began while deselected");
  read_launch_a: assert property (@(posedge link_clk) disable iff (reset)
    cmd_word == CMD_READ && gating_input && $past(gating_input) && input_buffers_on
    |=> array_read_valid && array_read_bank == $past(bank_select_bits)) else $error("Read not launched");
  col_block_a: assert property (@(posedge link_clk) disable iff (reset)
    array_read_valid |-> array_read_col_fall[COL_BITS-1:4] == array_read_col_rise[COL_BITS-1:4])
    else $error("Burst left its column block");
  strobe_drive_a: assert property (@(posedge link_clk) disable iff (reset)
    dq_oe |-> data_strobe_oe == 2'h3 && data_strobe_out_rise == 2'h3 && data_strobe_out_fall == 2'h0)
    else $error("Read strobe not edge aligned");
  lanes_off_a: assert property (@(posedge link_clk) disable iff (reset)
    !dq_oe |-> data_strobe_oe == 2'h0) else $error("Strobe lane driven without data");
  dq_follow_a: assert property (@(posedge link_clk) disable iff (reset)
    $rose(dq_oe) |-> $past(array_read_valid) || $past(array_read_valid, 2)) else $error("Data without read");
  buffers_off_a: assert property (@(posedge link_clk) disable iff (reset)
    input_buffers_on && !gating_input |-> ##[1:2] !input_buffers_on) else $error("Buffers stayed on");
  wake_up_a: assert property (@(posedge link_clk) disable iff (reset)
    !input_buffers_on && gating_input |-> ##[1:5] input_buffers_on) else $error("No exit from power down");
  // ------
  // Core domain check, with covers on both clocks
  // ------
  write_hold_a: assert property (@(posedge clk) disable iff (reset)
    write_valid && !write_ready |=> write_valid && $stable(write_word)) else $error("Write word dropped");
  cover property (@(posedge link_clk) disable iff (reset) $rose(dq_oe));
  cover property (@(posedge clk) disable iff (reset) write_valid && write_ready);
  cover property (@(posedge link_clk) disable iff (reset) $fell(input_buffers_on));
endmodule : lpddr_pin_interface_sva

bind lpddr_pin_interface lpddr_pin_interface_sva lpddr_pin_interface_sva_i (.*);

/* test/lpddr_ctl_model.sv */
// Controller model: drives command, address, gating and write beats on link_clk.
// Assumes the bench calls issue and beat; it also plays the array read port.
`timescale 1ns/1ps
module lpddr_ctl_model (
  input wire logic link_clk,
  input wire logic array_read_valid,
  input wire logic [lpddr_pin_pkg::ROW_BITS-1:0] array_read_row,
  input wire logic [lpddr_pin_pkg::COL_BITS-1:0] array_read_col_rise,
  input wire logic [lpddr_pin_pkg::COL_BITS-1:0] array_read_col_fall,
  output logic gating_input,
  output logic [3:0] cmd_pins,
  output logic [lpddr_pin_pkg::BANK_BITS-1:0] bank_select_bits,
  output logic [lpddr_pin_pkg::ROW_BITS-1:0] address_lines,
  output logic [lpddr_pin_pkg::DATA_BITS-1:0] dq_in_rise,
  output logic [lpddr_pin_pkg::DATA_BITS-1:0] dq_in_fall,
  output logic [lpddr_pin_pkg::LANES-1:0] write_byte_mask_rise,
  output logic [lpddr_pin_pkg::LANES-1:0] write_byte_mask_fall,
  output logic [lpddr_pin_pkg::DATA_BITS-1:0] array_read_data_rise,
  output logic [lpddr_pin_pkg::DATA_BITS-1:0] array_read_data_fall
);
  import lpddr_pin_pkg::*;
  logic [2*DATA_BITS+2*LANES-1:0] stage;
  initial
  begin
    gating_input = 1'b1;
    cmd_pins = 4'hF;
    {bank_select_bits, address_lines, dq_in_rise, dq_in_fall, write_byte_mask_rise, write_byte_mask_fall} = '0;
    stage = '0;
  end
  // Idle array port shows inverted data so a late sample cannot pass
  assign array_read_data_rise = {array_read_row[5:0], array_read_col_rise} ^ {16{!array_read_valid}};
  assign array_read_data_fall = {array_read_row[5:0], array_read_col_fall} ^ {16{!array_read_valid}};
  task automatic beat(input logic [2*DATA_BITS+2*LANES-1:0] b);
    stage = b;
  endtask : beat
  task automatic issue(input logic [3:0] c, input logic [1:0] ba, input logic [12:0] a, input logic g);
    @(posedge link_clk);
    cmd_pins <= c;
    bank_select_bits <= ba;
    address_lines <= a;
    gating_input <= g;
    {dq_in_rise, dq_in_fall, write_byte_mask_rise, write_byte_mask_fall} <= stage;
    stage = {$urandom, 4'($urandom)};
  endtask : issue
endmodule : lpddr_ctl_model

/* test/lpddr_pin_interface_tb.sv */
// Self-checking bench: reads, masked writes, FIFO overrun and power states.
// Assumes the controller model on the link side and a 48 ns link clock.
`timescale 1ns/1ps
module lpddr_pin_interface_tb;
  import lpddr_pin_pkg::*;
  logic clk, reset, link_clk, write_ready, overrun_clear, hold, track;
  logic gating_input, chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n, dq_oe, input_buffers_on;
  logic array_read_valid, write_valid, overrun_flag;
  logic [3:0] cmd_pins, power_state_core;
  logic [1:0] bank_select_bits, array_read_bank, write_byte_mask_rise, write_byte_mask_fall;
  logic [1:0] data_strobe_out_rise, data_strobe_out_fall, data_strobe_oe;
  logic [12:0] address_lines, array_read_row, row;
  logic [9:0] array_read_col_rise, array_read_col_fall, c;
  logic [15:0] dq_in_rise, dq_in_fall, dq_out_rise, dq_out_fall, array_read_data_rise, array_read_data_fall;
  logic [70:0] write_word;
  logic [35:0] b;
  logic [19:0] exp_col[$];
  logic [31:0] exp_dq[$];
  logic [70:0] exp_word[$];
  int fails, samples_checked, n;
  assign {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n} = cmd_pins;
  lpddr_pin_interface lpddr_pin_interface_i (.*);
  lpddr_ctl_model lpddr_ctl_model_i (.*);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // ------
  // Reporting and reference model
  // ------
  task automatic check(input string name, input logic [70:0] seen, input logic [70:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic cmd(input logic [3:0] k, input logic [1:0] ba, input logic [12:0] a, input logic g);
    lpddr_ctl_model_i.issue(k, ba, a, g);
  endtask : cmd
  // Burst order: sequential wraps in the block, interleave XORs the offset
  task automatic push_read(input int s, input int bl, input int il);
    int r, f;
    for (int k = 0; k < bl; k += 2)
    begin
      r = (s & ~(bl - 1)) | ((il ? s ^ k : s + k) & (bl - 1));
      f = (s & ~(bl - 1)) | ((il ? s ^ (k + 1) : s + k + 1) & (bl - 1));
      exp_col.push_back({10'(r), 10'(f)});
      exp_dq.push_back({row[5:0], 10'(r), row[5:0], 10'(f)});
    end
  endtask : push_read
  task automatic pwr(input logic [3:0] k, input logic [3:0] exp);
    cmd(k, 2'h0, 13'h0400, 1'b0);
    repeat (6) @(posedge link_clk);
    check("power_state", power_state_core, exp);
    check("buffers_down", input_buffers_on, 1'b0);
    cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1);
    repeat (8) @(posedge link_clk);
    check("power_run", power_state_core, PWR_RUN);
  endtask : pwr
  always @(posedge link_clk)
  begin
    if (array_read_valid === 1'b1)
      check("read_cols", {array_read_col_rise, array_read_col_fall}, exp_col.size() ? exp_col.pop_front() : 'x);
    if (dq_oe === 1'b1)
      check("read_data", {dq_out_rise, dq_out_fall}, exp_dq.size() ? exp_dq.pop_front() : 'x);
  end
  always @(posedge clk)
  begin
    write_ready <= hold ? 1'b0 : 1'($urandom);
    if (write_valid === 1'b1 && write_ready === 1'b1 && track === 1'b1)
      check("write_word", write_word, exp_word.size() ? exp_word.pop_front() : 'x);
  end
  initial
  begin
    #2000000;
    fails++;
    close_out();
  end
  // ------
  // Main sequence
  // ------
  initial
  begin
    void'($urandom(32'h6BEA));
    {reset, hold, track, overrun_clear} = 4'hA;
    // Reset lasts ten core cycles, outlasting four link edges
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge link_clk);
    check("reset_state", {input_buffers_on, write_valid, overrun_flag, power_state_core}, {3'h4, PWR_RUN});
    row = 13'($urandom);
    cmd(CMD_ACTIVE, 2'h2, row, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      cmd(CMD_MODE_LOAD, 2'h0, {9'h002, i[0], 3'h2}, 1'b1);
      cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1);
      c = 10'($urandom);
      if (i < 3)
        push_read(c, 4, i[0]);
      cmd(i == 3 ? 4'hD : CMD_READ, 2'h2, {3'h0, c}, 1'b1);
      repeat (3) cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1);
    end
    check("reads_done", exp_col.size() + exp_dq.size(), 0);
    cmd(CMD_MODE_LOAD, 2'h0, 13'h0021, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      c = 10'($urandom);
      b = {$urandom, 4'($urandom)};
      exp_word.push_back({2'h2, row, c, c ^ 10'h001, b[35:4], ~b[3:0]});
      cmd(CMD_WRITE, 2'h2, {3'h0, c}, 1'b1);
      lpddr_ctl_model_i.beat(b);
      repeat (2) cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1);
    end
    for (n = 0; n < 300 && exp_word.size() > 0; n++)
      @(posedge clk);
    check("writes_drained", exp_word.size(), 0);
    {hold, track} = 2'h2;
    cmd(CMD_MODE_LOAD, 2'h0, 13'h0024, 1'b1);
    repeat (2)
    begin
      cmd(CMD_WRITE, 2'h2, 13'h0000, 1'b1);
      repeat (9) cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1);
    end
    repeat (10) @(posedge clk);
    check("overrun_set", overrun_flag, 1'b1);
    hold = 1'b0;
    repeat (100) @(posedge clk);
    overrun_clear <= 1'b1;
    @(posedge clk);
    overrun_clear <= 1'b0;
    repeat (3) @(posedge clk);
    check("overrun_clear", {overrun_flag, write_valid}, 2'h0);
    pwr(CMD_NOP, PWR_ACTIVE_DOWN);
    cmd(CMD_PRECHARGE, 2'h0, 13'h0400, 1'b1);
    pwr(CMD_NOP, PWR_PRECHARGE_DOWN);
    pwr(CMD_REFRESH, PWR_SELF_REFRESH);
    close_out();
  end
endmodule : lpddr_pin_interface_tb
